// ==== verilog/phy_strap_config_latch.sv ====
// Added by the designer: the strobed register port and the register addresses.
`timescale 1ns/100ps
// Overview of operation
// - At reset release the speed strap is sampled and loaded into control bit 13, high meaning 100 Mbps.
// - The same speed strap sets the advertised 100 Mbps abilities in the advertisement register; both 10 Mbps abilities are set at capture whatever the straps.
// - At reset release the duplex strap is loaded into control bit 8, high meaning half duplex.
// - At reset release the auto-negotiation strap is loaded into control bit 12, high meaning enabled.
// - At reset release the address-zero strap is latched, high making address 0 unique, low broadcast.
// - At reset release the pin-test-chain strap is latched, low enabling that test mode.
// - Strap pins are pulled inputs during reset and until capture completes, four cycles after release, then drive as outputs; the board holds levels.
// - At reset release the isolate strap is loaded into the control isolate bit, high meaning isolate.
module phy_strap_config_latch (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [5:0] strap_in,
    input wire logic [5:0] strap_out_val,
    output logic [5:0] strap_out,
    output logic [5:0] strap_oe_n,
    output logic [5:0] strap_pull_en,
    input wire logic [4:0] addr,
    input wire logic [15:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [15:0] rdata,
    output logic speed_100,
    output logic full_duplex,
    output logic autoneg_en,
    output logic isolate_en,
    output logic addr_zero_unique,
    output logic chain_test_en
);
    // --------------------------------------------------------
    // Strap capture
    // --------------------------------------------------------
    strap_if sif ();
    logic done_r;
    logic [5:0] strap_r;
    logic [15:0] ctrl_r;
    logic [15:0] adv_r;
    logic [15:0] misc_r;
    logic [15:0] rdata_nxt;

    strap_capture #(.W(strap_pkg::strap_w)) u_cap (
        .clk(clk),
        .resetn(resetn),
        .pin_in(strap_in),
        .out(sif.cap)
    );

    // Capture done flag
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            done_r <= 1'b0;
        end else if (sif.load) begin
            done_r <= 1'b1;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            strap_r <= strap_pkg::strap_rst;
        end else if (sif.load && !done_r) begin
            strap_r <= sif.level;
        end
    end

    // --------------------------------------------------------
    // Pin direction
    // --------------------------------------------------------
    // inputs then outputs
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            strap_oe_n <= 6'h3f;
            strap_pull_en <= 6'h3f;
            strap_out <= 6'h00;
        end else begin
            strap_oe_n <= done_r ? 6'h00 : 6'h3f;
            strap_pull_en <= done_r ? 6'h00 : 6'h3f;
            strap_out <= done_r ? strap_out_val : 6'h00;
        end
    end

    // --------------------------------------------------------
    // Control register
    // --------------------------------------------------------
    // seed control
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ctrl_r <= strap_pkg::ctrl_rst;
        end else if (sif.load && !done_r) begin
            ctrl_r <= strap_pkg::ctrl_rst;
            ctrl_r[strap_pkg::ctrl_speed_bit] <= sif.level[strap_pkg::s_speed];
            ctrl_r[strap_pkg::ctrl_duplex_bit] <= ~sif.level[strap_pkg::s_duplex];
            ctrl_r[strap_pkg::ctrl_autoneg_bit] <= sif.level[strap_pkg::s_autoneg];
            ctrl_r[strap_pkg::ctrl_isolate_bit] <= sif.level[strap_pkg::s_isolate];
        end else if (wr && addr == strap_pkg::ctrl_addr) begin
            ctrl_r <= wdata;
        end
    end

    // --------------------------------------------------------
    // Advertisement register
    // --------------------------------------------------------
    // speed abilities
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            adv_r <= strap_pkg::adv_rst;
        end else if (sif.load && !done_r) begin
            adv_r <= strap_pkg::adv_rst;
            adv_r[strap_pkg::adv_100fd_bit] <= sif.level[strap_pkg::s_speed];
            adv_r[strap_pkg::adv_100hd_bit] <= sif.level[strap_pkg::s_speed];
            adv_r[strap_pkg::adv_10fd_bit] <= 1'b1;
            adv_r[strap_pkg::adv_10hd_bit] <= 1'b1;
        end else if (wr && addr == strap_pkg::adv_addr) begin
            adv_r <= wdata;
        end
    end

    // --------------------------------------------------------
    // Misc register
    // --------------------------------------------------------
    // latch modes
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            misc_r <= strap_pkg::misc_rst;
        end else if (sif.load && !done_r) begin
            misc_r <= strap_pkg::misc_rst;
            misc_r[strap_pkg::misc_bcast_bit] <= sif.level[strap_pkg::s_bcast];
            misc_r[strap_pkg::misc_chain_bit] <= ~sif.level[strap_pkg::s_chain_n];
        end else if (wr && addr == strap_pkg::misc_addr) begin
            misc_r <= wdata;
        end
    end

    // --------------------------------------------------------
    // Read path
    // --------------------------------------------------------
    // Address decode
    always_comb begin
        rdata_nxt = 16'h0000;
        if (addr == strap_pkg::ctrl_addr) begin
            rdata_nxt = ctrl_r;
        end else if (addr == strap_pkg::adv_addr) begin
            rdata_nxt = adv_r;
        end else if (addr == strap_pkg::misc_addr) begin
            rdata_nxt = misc_r;
        end else if (addr == strap_pkg::strap_addr) begin
            rdata_nxt = {9'h000, done_r, strap_r};
        end
    end

    // Read data one cycle later
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rdata <= 16'h0000;
        end else begin
            rdata <= rd ? rdata_nxt : 16'h0000;
        end
    end

    // Mode outputs
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            speed_100 <= 1'b0;
            full_duplex <= 1'b0;
            autoneg_en <= 1'b0;
            isolate_en <= 1'b0;
            addr_zero_unique <= 1'b0;
            chain_test_en <= 1'b0;
        end else begin
            speed_100 <= ctrl_r[strap_pkg::ctrl_speed_bit];
            full_duplex <= ctrl_r[strap_pkg::ctrl_duplex_bit];
            autoneg_en <= ctrl_r[strap_pkg::ctrl_autoneg_bit];
            isolate_en <= ctrl_r[strap_pkg::ctrl_isolate_bit];
            addr_zero_unique <= misc_r[strap_pkg::misc_bcast_bit];
            chain_test_en <= misc_r[strap_pkg::misc_chain_bit];
        end
    end
endmodule

// ==== verilog/strap_pkg.sv ====
package strap_pkg;
    // ------------------------------------------------------------
    // Register offsets (word index on the strobed port)
    // ------------------------------------------------------------
    localparam logic [4:0] ctrl_addr = 5'h00;
    localparam logic [4:0] adv_addr = 5'h04;
    localparam logic [4:0] misc_addr = 5'h10;
    localparam logic [4:0] strap_addr = 5'h11;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int ctrl_speed_bit = 13;
    localparam int ctrl_autoneg_bit = 12;
    localparam int ctrl_isolate_bit = 10;
    localparam int ctrl_duplex_bit = 8;
    localparam int adv_100fd_bit = 8;
    localparam int adv_100hd_bit = 7;
    localparam int adv_10fd_bit = 6;
    localparam int adv_10hd_bit = 5;
    localparam int misc_bcast_bit = 9;
    localparam int misc_chain_bit = 0;

    // ------------------------------------------------------------
    // Reset values before straps land
    // ------------------------------------------------------------
    localparam logic [15:0] ctrl_rst = 16'h0000;
    localparam logic [15:0] adv_rst = 16'h0001;
    localparam logic [15:0] misc_rst = 16'h0000;
    localparam logic [5:0] strap_rst = 6'h00;

    // Strap vector layout
    localparam int s_speed = 0;
    localparam int s_duplex = 1;
    localparam int s_autoneg = 2;
    localparam int s_isolate = 3;
    localparam int s_bcast = 4;
    localparam int s_chain_n = 5;
    localparam int strap_w = 6;

    // Release timing: seeding pulse on this count, counter saturates after
    localparam logic [1:0] load_cnt = 2'h2;
    localparam logic [1:0] rel_cnt_max = 2'h3;
endpackage

// ==== verilog/strap_if.sv ====
`timescale 1ns/100ps
// Carries captured straps from the capture stage to the register file
interface strap_if;
    logic [5:0] level;
    logic load;
    modport cap (output level, output load);
    modport reg_side (input level, input load);
endinterface

// ==== verilog/strap_capture.sv ====
`timescale 1ns/100ps
module strap_capture #(
    parameter int W = 6
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [W-1:0] pin_in,
    strap_if.cap out
);
    logic [W-1:0] s1_r;
    logic [W-1:0] s2_r;
    logic [1:0] rel_r;

    // Only the documented strap count is served
    if (W != strap_pkg::strap_w) begin : g_bad_width
        $error("strap width mismatch");
    end

    // Two-stage synchroniser on pins
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            s1_r <= '0;
            s2_r <= '0;
        end else begin
            s1_r <= pin_in;
            s2_r <= s1_r;
        end
    end

    // Release tracker; load fires once after release
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rel_r <= 2'h0;
        end else if (rel_r != strap_pkg::rel_cnt_max) begin
            rel_r <= rel_r + 2'h1;
        end
    end

    // Load pulse when synchronised pins reflect post-release levels
    assign out.load = (rel_r == strap_pkg::load_cnt);
    assign out.level = s2_r;
endmodule

// ==== dv/strap_latch_asserts.sv ====
`timescale 1ns/100ps
module strap_latch_asserts (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [5:0] strap_in,
    input wire logic [5:0] strap_out,
    input wire logic [5:0] strap_oe_n,
    input wire logic [5:0] strap_pull_en,
    input wire logic [4:0] addr,
    input wire logic [15:0] wdata,
    input wire logic wr,
    input wire logic speed_100,
    input wire logic full_duplex,
    input wire logic autoneg_en,
    input wire logic isolate_en,
    input wire logic addr_zero_unique,
    input wire logic chain_test_en
);
    logic [2:0] cnt_r;
    // Edges since reset release, saturating
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cnt_r <= 3'h0;
        end else if (cnt_r != 3'h7) begin
            cnt_r <= cnt_r + 3'h1;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    a_pins_stay_in: assert property (cnt_r < 3'h4 |-> (strap_oe_n & strap_pull_en) == 6'h3f)
        else $error("pins left input duty early");
    a_pins_go_out: assert property (cnt_r >= 3'h4 |-> (strap_oe_n | strap_pull_en) == 6'h00)
        else $error("pins not driving after capture");
    a_speed_duplex_seed: assert property (cnt_r == 3'h4 |-> speed_100 == $past(strap_in[0], 3)
        && full_duplex == !$past(strap_in[1], 3)) else $error("speed or duplex seed wrong");
    a_autoneg_iso_seed: assert property (cnt_r == 3'h4 |-> autoneg_en == $past(strap_in[2], 3)
        && isolate_en == $past(strap_in[3], 3)) else $error("autoneg or isolate seed wrong");
    a_bcast_chain_seed: assert property (cnt_r == 3'h4 |-> addr_zero_unique == $past(strap_in[4], 3)
        && chain_test_en == !$past(strap_in[5], 3)) else $error("addr zero or chain seed wrong");
    a_mode_holds: assert property (cnt_r == 3'h7 && !$past(wr) && !$past(wr, 2) |->
        $stable({speed_100, full_duplex, autoneg_en, isolate_en, addr_zero_unique, chain_test_en}))
        else $error("mode changed without a write");
    a_write_wins: assert property (cnt_r == 3'h7 && $past(wr, 2) && $past(addr, 2) == strap_pkg::ctrl_addr |->
        speed_100 == $past(wdata[13], 2) && autoneg_en == $past(wdata[12], 2)) else $error("write did not override");
    a_isolate_write: assert property (cnt_r == 3'h7 && $past(wr, 2) && $past(addr, 2) == strap_pkg::ctrl_addr |->
        isolate_en == $past(wdata[10], 2)) else $error("isolate write lost");
endmodule
bind phy_strap_config_latch strap_latch_asserts u_chk (.*);

// ==== dv/strap_board.sv ====
`timescale 1ns/100ps
module strap_board (
    input wire logic [5:0] level,
    input wire logic [5:0] strap_out,
    input wire logic [5:0] strap_oe_n,
    output logic [5:0] strap_in
);
    // board holds levels
    // Device drive when enabled, resistor level otherwise
    assign strap_in = (strap_oe_n & level) | (~strap_oe_n & strap_out);
endmodule

// ==== dv/phy_strap_config_latch_tb_top.sv ====
`timescale 1ns/100ps
module phy_strap_config_latch_tb_top;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic [5:0] level = 6'h27;
    logic [5:0] strap_out_val = 6'h2d;
    logic [4:0] addr = 5'h00;
    logic [15:0] wdata = 16'h0000;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [5:0] strap_in, strap_out, strap_oe_n, strap_pull_en, mode;
    logic [15:0] rdata, v;
    int mismatches = 0;
    int checks_done = 0;
    phy_strap_config_latch u_dut (.clk(clk), .resetn(resetn), .strap_in(strap_in), .strap_out_val(strap_out_val),
        .strap_out(strap_out), .strap_oe_n(strap_oe_n), .strap_pull_en(strap_pull_en), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd), .rdata(rdata), .speed_100(mode[0]), .full_duplex(mode[1]), .autoneg_en(mode[2]),
        .isolate_en(mode[3]), .addr_zero_unique(mode[4]), .chain_test_en(mode[5]));
    strap_board u_board (.level(level), .strap_out(strap_out), .strap_oe_n(strap_oe_n), .strap_in(strap_in));
    initial begin
        forever #2 clk = ~clk;
    end
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wr_reg(input logic [4:0] a, input logic [15:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [4:0] a, output logic [15:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask
    // Reset with given straps, then read back seeded state
    task automatic power_up(input logic [5:0] s);
        @(posedge clk);
        level <= s;
        resetn <= 1'b0;
        repeat (20) @(posedge clk);
        resetn <= 1'b1;
        repeat (6) @(posedge clk);
        #1 check(mode, s ^ 6'h22);
        check(strap_oe_n | strap_pull_en, 6'h00);
        rd_reg(strap_pkg::ctrl_addr, v);
        check(v, {2'b00, s[0], s[2], 1'b0, s[3], 1'b0, ~s[1], 8'h00});
        rd_reg(strap_pkg::adv_addr, v);
        check(v, {7'h00, s[0], s[0], 2'b11, 4'h0, 1'b1});
        rd_reg(strap_pkg::misc_addr, v);
        check(v, {6'h00, s[4], 8'h00, ~s[5]});
    endtask
    // Software override, pin drive and unmapped access
    task automatic override_run;
        wr_reg(strap_pkg::ctrl_addr, 16'h2500);
        rd_reg(strap_pkg::ctrl_addr, v);
        check(v, 16'h2500);
        repeat (2) @(posedge clk);
        #1 check(mode[3:0], 4'hb);
        check(strap_out, 6'h2d);
        rd_reg(strap_pkg::strap_addr, v);
        check(v, {9'h000, 1'b1, level});
        wr_reg(5'h1f, 16'hffff);
        rd_reg(5'h1f, v);
        check(v, 16'h0000);
        rd_reg(strap_pkg::ctrl_addr, v);
        check(v, 16'h2500);
        wr_reg(strap_pkg::misc_addr, 16'h0201);
        wr_reg(strap_pkg::adv_addr, 16'h01e1);
        rd_reg(strap_pkg::adv_addr, v);
        check(v, 16'h01e1);
        #1 check(mode[5:4], 2'h3);
    endtask
    task automatic print_verdict;
        $display("checks_done=%0d mismatches=%0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    initial begin
        power_up(6'h27);
        power_up(6'h18);
        power_up(6'h15);
        power_up(6'h2a);
        override_run();
        print_verdict();
    end
    initial begin
        #20000;
        mismatches++;
        print_verdict();
    end
endmodule
